// *** hw/phy_link_power_config_regs.sv ***
`timescale 1ns/1ns
// Overview of operation
// - Link pulse enable; cleared forces good link in 10M only
// - Heartbeat enable, ignored in full duplex
// - Jabber enable in 10M full or loopback
// - Polarity reversed status follows 10BASE-T logic
// - Top reserved 10BASE-T bit reads zero
// - Nine power-down test bits, read-write
// - Shared value drives selected power-down fields
// - Force 100M signal detect good
// - Preamble cut ten or five bits, only while 10M transmit power saving is also on
// - 10M transmit power saving enable
// - Autoneg power saving, inverted sense
// - Crossover status: one crossed, zero straight
// - Autoneg digital loopback test
// - Crossover override follows force-value bit
module phy_link_power_config_regs
	import phy_cfg_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic [4:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic SPEED_10M,
	input wire logic FULL_DUPLEX,
	input wire logic LOOPBACK_10M,
	input wire logic RX_POL_REV,
	input wire logic AUTO_XOVER,
	input wire logic SIG_DETECT_100,
	output logic LINK_PULSE_TX,
	output logic LINK_GOOD_FORCE,
	output logic HEARTBEAT_ON,
	output logic SQUELCH_NORMAL,
	output logic JABBER_ON,
	output logic SIG_DETECT_OUT,
	output logic [3:0] PREAMBLE_CUT,
	output logic TX10M_SAVE,
	output logic AN_PWR_SAVE,
	output logic AN_LOOPBACK,
	output logic XOVER_MDIX,
	output logic RMII_V10,
	output logic [PD_FIELDS-1:0] PD_CTRL
);
	// Stored register bits
	logic [15:0] tenbt;
	logic [15:0] pdtest;
	logic [15:0] spcfg;
	logic [15:0] psave;
	// Live status bits
	logic polarity_reversed;
	logic crossover_status;
	logic [15:0] next_rdata;

	// Merge write data into writable bits only
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	// Write strobe aimed at one register index
	function automatic logic reg_hit(input logic strobe, input logic [4:0] idx, input logic [4:0] a);
		reg_hit = strobe && (idx == a);
	endfunction

	// 10BASE-T register writes; top bit never stored
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			tenbt <= TENBT_RST;
		end else if (reg_hit(WR, ADDR, ADDR_TENBT)) begin
			tenbt <= merge(tenbt, WDATA, TENBT_WMASK);
		end
	end

	// Power-down test register writes
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			pdtest <= PDTEST_RST;
		end else if (reg_hit(WR, ADDR, ADDR_PDTEST)) begin
			pdtest <= merge(pdtest, WDATA, PDTEST_WMASK);
		end
	end

	// Specified configuration register writes
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			spcfg <= SPCFG_RST;
		end else if (reg_hit(WR, ADDR, ADDR_SPCFG)) begin
			spcfg <= merge(spcfg, WDATA, SPCFG_WMASK);
		end
	end

	// Power saving register writes (preamble length select)
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			psave <= PSAVE_RST;
		end else if (reg_hit(WR, ADDR, ADDR_PSAVE)) begin
			psave <= merge(psave, WDATA, PSAVE_WMASK);
		end
	end

	// Status flops: polarity and crossover state
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			polarity_reversed <= 1'b0;
			crossover_status <= 1'b0;
		end else begin
			polarity_reversed <= SPEED_10M & RX_POL_REV;
			if (spcfg[B_XOVER_OVR]) begin
				crossover_status <= spcfg[B_XOVER_VAL];
			end else begin
				crossover_status <= AUTO_XOVER;
			end
		end
	end

	// Read data mux
	always_comb begin
		next_rdata = 16'h0000;
		case (ADDR)
			ADDR_TENBT: begin
				next_rdata = tenbt;
				next_rdata[B_POLARITY] = polarity_reversed;
				next_rdata[B_TENBT_TOP] = 1'b0;
			end
			ADDR_PDTEST: next_rdata = pdtest;
			ADDR_SPCFG: begin
				next_rdata = spcfg;
				next_rdata[B_XOVER] = crossover_status;
			end
			ADDR_PSAVE: next_rdata = psave;
			default: next_rdata = 16'h0000;
		endcase
	end

	// Read data held only in the cycle after a read
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			RDATA <= 16'h0000;
		end else if (RD) begin
			RDATA <= next_rdata;
		end else begin
			RDATA <= 16'h0000;
		end
	end

	// 10M link controls
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			LINK_PULSE_TX <= 1'b0;
			LINK_GOOD_FORCE <= 1'b0;
			HEARTBEAT_ON <= 1'b0;
			SQUELCH_NORMAL <= 1'b1;
			JABBER_ON <= 1'b0;
		end else begin
			LINK_PULSE_TX <= SPEED_10M & tenbt[B_LINK_PULSE];
			LINK_GOOD_FORCE <= SPEED_10M & ~tenbt[B_LINK_PULSE];
			HEARTBEAT_ON <= tenbt[B_HEARTBEAT] & ~FULL_DUPLEX;
			SQUELCH_NORMAL <= tenbt[B_SQUELCH];
			JABBER_ON <= tenbt[B_JABBER] & SPEED_10M & (FULL_DUPLEX | LOOPBACK_10M);
		end
	end

	// Configuration controls
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			SIG_DETECT_OUT <= 1'b0;
			PREAMBLE_CUT <= PRE_CUT_NONE;
			TX10M_SAVE <= 1'b0;
			AN_PWR_SAVE <= 1'b1;
			AN_LOOPBACK <= 1'b0;
			XOVER_MDIX <= 1'b0;
			RMII_V10 <= 1'b0;
		end else begin
			SIG_DETECT_OUT <= spcfg[B_FORCE_SD] | SIG_DETECT_100;
			if (spcfg[B_PREAMBLE] && spcfg[B_TX_10M_POWER_SAVING]) begin
				PREAMBLE_CUT <= psave[B_PRE_LONG] ? PRE_CUT_LONG : PRE_CUT_SHORT;
			end else begin
				PREAMBLE_CUT <= PRE_CUT_NONE;
			end
			TX10M_SAVE <= spcfg[B_TX_10M_POWER_SAVING];
			AN_PWR_SAVE <= ~spcfg[B_AN_PWR_DIS];
			AN_LOOPBACK <= spcfg[B_AN_LOOP];
			XOVER_MDIX <= crossover_status;
			RMII_V10 <= spcfg[B_RMII_VER];
		end
	end

	// Selected power-down fields take the shared value
	pd_field_apply #(.N(PD_FIELDS)) u_pd (
		.SYS_CLK(SYS_CLK),
		.SYS_RST(SYS_RST),
		.select(pdtest[PD_FIELDS-1:0]),
		.value(spcfg[B_POWER_DOWN_VALUE]),
		.pd_out(PD_CTRL)
	);

	// Assertions
	chk_pulse_enable: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		SPEED_10M && !tenbt[B_LINK_PULSE] |=> LINK_GOOD_FORCE && !LINK_PULSE_TX)
		else $error("link pulses not suppressed");
	chk_heartbeat_fdx: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		FULL_DUPLEX |=> !HEARTBEAT_ON)
		else $error("heartbeat active in full duplex");
	chk_squelch_sel: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		WR && ADDR == ADDR_TENBT ##2 1 |-> SQUELCH_NORMAL == $past(WDATA[B_SQUELCH], 2))
		else $error("squelch select wrong");
	chk_top_zero: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		RD && ADDR == ADDR_TENBT |=> RDATA[15] == 1'b0)
		else $error("reserved top bit read nonzero");
	chk_polarity_read: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		SPEED_10M && RX_POL_REV ##1 RD && ADDR == ADDR_TENBT |=> RDATA[B_POLARITY])
		else $error("polarity status not reported");
	chk_pd_apply: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		pdtest[0] && spcfg[B_POWER_DOWN_VALUE] |=> PD_CTRL[0])
		else $error("selected field not powered down");
	chk_preamble_cut: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		spcfg[B_PREAMBLE] && spcfg[B_TX_10M_POWER_SAVING] && !psave[B_PRE_LONG] |=>
		PREAMBLE_CUT == PRE_CUT_SHORT)
		else $error("preamble reduction wrong");
	chk_an_inverted: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		spcfg[B_AN_PWR_DIS] |=> !AN_PWR_SAVE)
		else $error("autoneg power saving sense wrong");
	chk_xover_force: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		spcfg[B_XOVER_OVR] ##1 spcfg[B_XOVER_OVR] |=> XOVER_MDIX == $past(spcfg[B_XOVER_VAL], 2))
		else $error("crossover override ignored");
	// Link pulse and heartbeat controls
	chk_pulse_on: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		SPEED_10M && tenbt[B_LINK_PULSE] |=> LINK_PULSE_TX && !LINK_GOOD_FORCE)
		else $error("link pulses not sent");
	chk_pulse_100m: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!SPEED_10M |=> !LINK_PULSE_TX && !LINK_GOOD_FORCE)
		else $error("link pulse control active outside 10M");
	chk_heartbeat_on: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!SYS_RST && tenbt[B_HEARTBEAT] && !FULL_DUPLEX |=> HEARTBEAT_ON)
		else $error("heartbeat missing in half duplex");
	// Jabber only in its two modes
	chk_jabber_on: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		tenbt[B_JABBER] && SPEED_10M && (FULL_DUPLEX || LOOPBACK_10M) |=> JABBER_ON)
		else $error("jabber not enabled");
	chk_jabber_off: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!tenbt[B_JABBER] || !SPEED_10M || !(FULL_DUPLEX || LOOPBACK_10M) |=> !JABBER_ON)
		else $error("jabber enabled outside its modes");
	// Live status bits
	chk_polarity_clear: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!SYS_RST && !(SPEED_10M && RX_POL_REV) |=> !polarity_reversed)
		else $error("polarity status not cleared");
	chk_xover_auto: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!SYS_RST && !spcfg[B_XOVER_OVR] |-> ##2 XOVER_MDIX == $past(AUTO_XOVER, 2))
		else $error("crossover status not following detection");
	// Power-down test fields and shared value
	chk_pd_store: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		WR && ADDR == ADDR_PDTEST |=> pdtest[PD_FIELDS-1:0] == $past(WDATA[PD_FIELDS-1:0]))
		else $error("power-down test bits not stored");
	chk_pd_unsel: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!pdtest[0] |=> !PD_CTRL[0])
		else $error("unselected field powered down");
	chk_pd_normal: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!spcfg[B_POWER_DOWN_VALUE] |=> PD_CTRL == {PD_FIELDS{1'b0}})
		else $error("power-down applied while value is normal");
	chk_pd_top: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		pdtest[PD_FIELDS-1] && spcfg[B_POWER_DOWN_VALUE] |=> PD_CTRL[PD_FIELDS-1])
		else $error("top field not powered down");
	// Configuration controls
	chk_sd_force: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		spcfg[B_FORCE_SD] |=> SIG_DETECT_OUT)
		else $error("signal detect not forced");
	chk_sd_normal: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!SYS_RST && !spcfg[B_FORCE_SD] |=> SIG_DETECT_OUT == $past(SIG_DETECT_100))
		else $error("signal detect not following input");
	chk_cut_long: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		spcfg[B_PREAMBLE] && spcfg[B_TX_10M_POWER_SAVING] && psave[B_PRE_LONG] |=>
		PREAMBLE_CUT == PRE_CUT_LONG)
		else $error("long preamble reduction wrong");
	chk_cut_none: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!(spcfg[B_PREAMBLE] && spcfg[B_TX_10M_POWER_SAVING]) |=> PREAMBLE_CUT == PRE_CUT_NONE)
		else $error("preamble reduced without both enables");
	chk_tx_save: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!SYS_RST |=> TX10M_SAVE == $past(spcfg[B_TX_10M_POWER_SAVING]))
		else $error("10M transmit saving wrong");
	chk_an_enabled: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!spcfg[B_AN_PWR_DIS] |=> AN_PWR_SAVE)
		else $error("autoneg power saving not enabled");
	chk_an_loop: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!SYS_RST |=> AN_LOOPBACK == $past(spcfg[B_AN_LOOP]))
		else $error("autoneg loopback wrong");
	chk_rmii_sel: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!SYS_RST |=> RMII_V10 == $past(spcfg[B_RMII_VER]))
		else $error("RMII version select wrong");
	chk_spcfg_hold: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		!SYS_RST && !(WR && ADDR == ADDR_SPCFG) |=> $stable(spcfg))
		else $error("configuration bits changed without a write");
	chk_spcfg_store: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		WR && ADDR == ADDR_SPCFG |=> spcfg == $past(WDATA & SPCFG_WMASK))
		else $error("configuration write not stored");
	cov_tenbt_write: cover property (@(posedge SYS_CLK) WR && ADDR == ADDR_TENBT);
	cov_pd_on: cover property (@(posedge SYS_CLK) |PD_CTRL);
	cov_cut_long: cover property (@(posedge SYS_CLK) PREAMBLE_CUT == PRE_CUT_LONG);
	cov_xover_forced: cover property (@(posedge SYS_CLK) spcfg[B_XOVER_OVR] && XOVER_MDIX);
	cov_polarity_read: cover property (@(posedge SYS_CLK) RD && ADDR == ADDR_TENBT && polarity_reversed);
endmodule

// *** include/phy_cfg_pkg.sv ***
package phy_cfg_pkg;
	// Register indices on the management port
	localparam logic [4:0] ADDR_TENBT = 5'h12;
	localparam logic [4:0] ADDR_PDTEST = 5'h13;
	localparam logic [4:0] ADDR_SPCFG = 5'h14;
	localparam logic [4:0] ADDR_PSAVE = 5'h1D;
	// Reset values
	localparam logic [15:0] TENBT_RST = 16'h7802;
	localparam logic [15:0] PDTEST_RST = 16'h0000;
	localparam logic [15:0] SPCFG_RST = 16'h0000;
	localparam logic [15:0] PSAVE_RST = 16'h0000;
	// Writable masks
	localparam logic [15:0] TENBT_WMASK = 16'h7C02;
	localparam logic [15:0] PDTEST_WMASK = 16'h01FF;
	localparam logic [15:0] SPCFG_WMASK = 16'hFE7F;
	localparam logic [15:0] PSAVE_WMASK = 16'h0E00;
	// Field positions, 10BASE-T register
	localparam int B_LINK_PULSE = 14;
	localparam int B_HEARTBEAT = 13;
	localparam int B_SQUELCH = 12;
	localparam int B_JABBER = 11;
	localparam int B_POLARITY = 0;
	localparam int B_TENBT_TOP = 15;
	// Field positions, specified configuration register
	localparam int B_FORCE_SD = 13;
	localparam int B_PREAMBLE = 11;
	localparam int B_TX_10M_POWER_SAVING = 10;
	localparam int B_AN_PWR_DIS = 9;
	localparam int B_XOVER = 7;
	localparam int B_AN_LOOP = 6;
	localparam int B_XOVER_VAL = 5;
	localparam int B_XOVER_OVR = 4;
	localparam int B_RMII_VER = 1;
	localparam int B_POWER_DOWN_VALUE = 0;
	// Field position, power saving register
	localparam int B_PRE_LONG = 11;
	// Count of power-down test fields
	localparam int PD_FIELDS = 9;
	// Preamble reductions in bits
	localparam logic [3:0] PRE_CUT_LONG = 4'hA;
	localparam logic [3:0] PRE_CUT_SHORT = 4'h5;
	localparam logic [3:0] PRE_CUT_NONE = 4'h0;
endpackage

// *** hw/pd_field_apply.sv ***
`timescale 1ns/1ns
// Drives each selected power-down field with the shared value
module pd_field_apply
	import phy_cfg_pkg::*;
#(
	parameter int N = PD_FIELDS
) (
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic [N-1:0] select,
	input wire logic value,
	output logic [N-1:0] pd_out
);
	// One flop per field; unselected fields stay in normal operation
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_fld
			always_ff @(posedge SYS_CLK) begin
				if (SYS_RST) begin
					pd_out[i] <= 1'b0;
				end else begin
					pd_out[i] <= select[i] & value;
				end
			end
		end
	endgenerate
endmodule

// *** tb/mgmt_master.sv ***
`timescale 1ns/1ns
// Management-side master: one-cycle strobes, read data taken the cycle after
module mgmt_master
	import phy_cfg_pkg::*;
(
	input wire logic sys_clk,
	output logic [4:0] addr,
	output logic [15:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [15:0] rdata
);
	// Bus idle from time zero
	initial begin
		addr = 5'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	// One write cycle; strobe stays up for a following write
	task automatic write(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] m;
		// Heartbeat bit kept at one, top reserved bit kept at zero
		m = (a == ADDR_TENBT) ? ((d | 16'h2000) & 16'h7FFF) : d;
		@(posedge sys_clk);
		addr <= a;
		wdata <= m;
		wr <= 1'b1;
		rd <= 1'b0;
	endtask
	// One read cycle; data taken in the cycle after the strobe
	task automatic read(input logic [4:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Idle cycles with both strobes low
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			wr <= 1'b0;
			rd <= 1'b0;
		end
	endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ns
// Random register traffic with live status inputs; shadows predict reads and outputs
module testbench;
	import phy_cfg_pkg::*;
	logic sys_clk = 1'b0; // 250 MHz clock
	logic sys_rst = 1'b1; // Synchronous reset
	logic [5:0] st = 6'h00; // 10M, duplex, loopback, polarity, auto crossover, detect
	logic [15:0] t, p, s, v, w, rv; // Shadows, write word, read word
	logic [4:0] addr;
	logic [15:0] wdata, rdata;
	logic wr, rd;
	wire [23:0] ov; // Packed control outputs
	int failures = 0;
	int num_checks = 0;
	localparam logic [4:0] IDX [5] = '{ADDR_TENBT, ADDR_PDTEST, ADDR_SPCFG, ADDR_PSAVE, 5'h1F};
	always #2 sys_clk = ~sys_clk;
	mgmt_master i_mgmt_master (.sys_clk(sys_clk), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata));
	phy_link_power_config_regs i_phy_link_power_config_regs (.SYS_CLK(sys_clk),
		.SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.SPEED_10M(st[5]), .FULL_DUPLEX(st[4]), .LOOPBACK_10M(st[3]), .RX_POL_REV(st[2]),
		.AUTO_XOVER(st[1]), .SIG_DETECT_100(st[0]), .LINK_PULSE_TX(ov[23]),
		.LINK_GOOD_FORCE(ov[22]), .HEARTBEAT_ON(ov[21]), .SQUELCH_NORMAL(ov[20]),
		.JABBER_ON(ov[19]), .SIG_DETECT_OUT(ov[18]), .PREAMBLE_CUT(ov[17:14]),
		.TX10M_SAVE(ov[13]), .AN_PWR_SAVE(ov[12]), .AN_LOOPBACK(ov[11]),
		.XOVER_MDIX(ov[10]), .RMII_V10(ov[9]), .PD_CTRL(ov[8:0]));
	// Crossover state: forced value or automatic detection
	function automatic logic xo();
		return s[B_XOVER_OVR] ? s[B_XOVER_VAL] : st[1];
	endfunction
	// Expected control outputs from shadows and status inputs
	function automatic logic [23:0] exp_out();
		logic [3:0] c;
		c = (s[B_PREAMBLE] & s[B_TX_10M_POWER_SAVING]) ? (v[B_PRE_LONG] ? 4'hA : 4'h5) : 4'h0;
		return {st[5] & t[B_LINK_PULSE], st[5] & ~t[B_LINK_PULSE], t[B_HEARTBEAT] & ~st[4],
			t[B_SQUELCH], t[B_JABBER] & st[5] & (st[4] | st[3]), s[B_FORCE_SD] | st[0], c,
			s[B_TX_10M_POWER_SAVING], ~s[B_AN_PWR_DIS], s[B_AN_LOOP], xo(), s[B_RMII_VER],
			p[8:0] & {9{s[B_POWER_DOWN_VALUE]}}};
	endfunction
	// Expected read word; live status bits merged in
	function automatic logic [15:0] exp_rd(input logic [4:0] a);
		case (a)
			ADDR_TENBT: return t | {15'h0000, st[5] & st[2]};
			ADDR_PDTEST: return p;
			ADDR_SPCFG: return (s & 16'hFF7F) | {8'h00, xo(), 7'h00};
			ADDR_PSAVE: return v;
			default: return 16'h0000;
		endcase
	endfunction
	// Counts and reports one comparison
	task automatic cmp(input logic [23:0] g, input logic [23:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Read result against prediction
	task automatic chk_rd(input logic [4:0] a);
		i_mgmt_master.read(a, rv);
		cmp({8'h00, rv}, {8'h00, exp_rd(a)});
	endtask
	// Write and shadow update; only writable bits move
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] m;
		m = (a == ADDR_TENBT) ? ((d | 16'h2000) & 16'h7FFF) : d;
		i_mgmt_master.write(a, d);
		case (a)
			ADDR_TENBT: t = (m & TENBT_WMASK) | (t & ~TENBT_WMASK);
			ADDR_PDTEST: p = (m & PDTEST_WMASK) | (p & ~PDTEST_WMASK);
			ADDR_SPCFG: s = (m & SPCFG_WMASK) | (s & ~SPCFG_WMASK);
			ADDR_PSAVE: v = (m & PSAVE_WMASK) | (v & ~PSAVE_WMASK);
			default: ;
		endcase
	endtask
	// Prints counts and verdict, ends the run
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Guard against a hung run
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		summarize();
	end
	// Reset values, then corner and random traffic
	initial begin
		void'($urandom(32'h5E36));
		t = TENBT_RST;
		p = PDTEST_RST;
		s = SPCFG_RST;
		v = PSAVE_RST;
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		i_mgmt_master.idle(3);
		cmp(ov, exp_out());
		foreach (IDX[k]) chk_rd(IDX[k]);
		for (int i = 0; i < 40; i++) begin
			w = (i == 0) ? 16'h0000 : ((i < 3) ? 16'hFFFF : 16'($urandom));
			@(posedge sys_clk);
			st <= (i < 3) ? 6'h3F : 6'($urandom);
			// Back-to-back writes, one to an unmapped index
			wr_reg(ADDR_TENBT, w);
			wr_reg(ADDR_PDTEST, w ^ 16'h00AA);
			wr_reg(ADDR_SPCFG, w);
			wr_reg(ADDR_PSAVE, (i == 2) ? 16'h0000 : w);
			wr_reg(5'($urandom % 18), ~w);
			i_mgmt_master.idle(4);
			cmp(ov, exp_out());
			foreach (IDX[k]) chk_rd(IDX[k]);
		end
		summarize();
	end
endmodule
